// file: core/mrm_register_bank.sv
// Purpose: Register bank of the magnetometer behind its serial port.
// Assumes: The serial clock, select and data pins are asynchronous and
//          much slower than clock; measurement inputs share clock.
// Notes:   Serial modes 0 and 3; first byte is read flag plus address,
//          then data bytes with auto-incrementing address.
// How it works
// R1: Identification reads its value only when powered.
// R2: X low holds field bits 4..0 at 7..3.
// R3: X high holds field bits 12..5.
// R4: Y field split exactly like X.
// R5: X and Y low bits 2,1 read zero.
// R6: X, Y and Z low byte bit 0 is check flag, default one.
// R7: Z is 15 bits, split 7 and 8.
// R8: Two repetition count registers, writable, reset zero.
// R9: Reserved register after identification has no behaviour.
// R10: Hall low: bits 5..0, zero, ready flag.
// R11: Both soft reset bits reset all but power control.
// R12: Power bit moves between suspend and sleep.
// R13: Three-wire select bit turns data pin bidirectional.
// R14: Writes to read-only registers change nothing.
`timescale 1ns/1ps
module mrm_register_bank #(
  parameter logic [7:0] ID_VALUE = 8'ha5  // Arbitrary neutral value.
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       spiClk,
  input  wire logic                       chipSelN,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOe,
  output logic                            sdoOut,
  output logic                            sdoOe,
  input  wire logic                       sampleLoad,
  input  wire logic [mrm_pkg::XY_W-1:0]   xField,
  input  wire logic [mrm_pkg::XY_W-1:0]   yField,
  input  wire logic [mrm_pkg::Z_W-1:0]    zField,
  input  wire logic [mrm_pkg::HALL_W-1:0] hallValue,
  input  wire logic                       xCheck,
  input  wire logic                       yCheck,
  input  wire logic                       zCheck,
  input  wire logic                       sampleAvail,
  input  wire logic [7:0]                 intFlagsIn,
  output logic                            powerOn,
  output logic                            threeWireSelect,
  output logic                            softResetPulse,
  output logic [7:0]                      opControl,
  output logic [7:0]                      intEnables,
  output logic [7:0]                      intPinConfig,
  output logic [7:0]                      lowThreshold,
  output logic [7:0]                      highThreshold,
  output logic [7:0]                      planarRepetitionCount,
  output logic [7:0]                      verticalRepetitionCount
);

  // Pin synchronisers and edge history.
  logic                       sckS1_r;
  logic                       sckS2_r;
  logic                       sckS3_r;
  logic                       csS1_r;
  logic                       csS2_r;
  logic                       sdaS1_r;
  logic                       sdaS2_r;
  logic                       sckRise;
  logic                       sckFall;
  logic                       csActive;
  // Frame state.
  mrm_pkg::mrm_state_t        state_r;
  logic [2:0]                 bitCnt_r;
  logic [7:0]                 shIn_r;
  logic [7:0]                 byteIn;
  logic                       byteDone;
  logic [6:0]                 addr_r;
  logic [7:0]                 txSh_r;
  logic                       txBit_r;
  // Write strobe handed to the register bank.
  logic                       wrFire_r;
  logic [6:0]                 wrAddr_r;
  logic [7:0]                 wrData_r;
  logic                       softFire;
  logic                       bankClear;
  // Registers.
  logic                       powerOn_r;
  logic                       threeWire_r;
  logic                       softPulse_r;
  logic [7:0]                 opCtl_r;
  logic [7:0]                 intEn_r;
  logic [7:0]                 pinCfg_r;
  logic [7:0]                 lowThr_r;
  logic [7:0]                 highThr_r;
  logic [7:0]                 planar_repetition_count_r;
  logic [7:0]                 vertical_repetition_count_r;
  logic [mrm_pkg::XY_W-1:0]   xField_r;
  logic [mrm_pkg::XY_W-1:0]   yField_r;
  logic [mrm_pkg::Z_W-1:0]    zField_r;
  logic [mrm_pkg::HALL_W-1:0] hall_r;
  logic                       xCheck_r;
  logic                       yCheck_r;
  logic                       zCheck_r;
  logic                       ready_r;
  logic [7:0]                 intFlags_r;

  // Read multiplexer; in suspend only power control is visible.
  function automatic logic [7:0] rdMux(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == mrm_pkg::ADDR_PWR_CTL) begin
      d = {5'h00, threeWire_r, 1'b0, powerOn_r};  // R11
    end else if (!powerOn_r) begin
      d = 8'h00;  // R1
    end else if (a == mrm_pkg::ADDR_IDENT) begin
      d = ID_VALUE;  // R1
    end else if (a == mrm_pkg::ADDR_X_LOW) begin
      d = {xField_r[4:0], 2'b00, xCheck_r};  // R2 R5
    end else if (a == mrm_pkg::ADDR_X_HIGH) begin
      d = xField_r[12:5];  // R3
    end else if (a == mrm_pkg::ADDR_Y_LOW) begin
      d = {yField_r[4:0], 2'b00, yCheck_r};  // R4 R5
    end else if (a == mrm_pkg::ADDR_Y_HIGH) begin
      d = yField_r[12:5];  // R4
    end else if (a == mrm_pkg::ADDR_Z_LOW) begin
      d = {zField_r[6:0], zCheck_r};  // R7
    end else if (a == mrm_pkg::ADDR_Z_HIGH) begin
      d = zField_r[14:7];  // R7
    end else if (a == mrm_pkg::ADDR_HALL_LOW) begin
      d = {hall_r[5:0], 1'b0, ready_r};  // R10
    end else if (a == mrm_pkg::ADDR_HALL_HIGH) begin
      d = hall_r[13:6];  // R10
    end else if (a == mrm_pkg::ADDR_INT_FLAGS) begin
      d = intFlags_r;
    end else if (a == mrm_pkg::ADDR_OP_CTL) begin
      d = opCtl_r;
    end else if (a == mrm_pkg::ADDR_INT_EN) begin
      d = intEn_r;
    end else if (a == mrm_pkg::ADDR_PIN_CFG) begin
      d = pinCfg_r;
    end else if (a == mrm_pkg::ADDR_LOW_THR) begin
      d = lowThr_r;
    end else if (a == mrm_pkg::ADDR_HIGH_THR) begin
      d = highThr_r;
    end else if (a == mrm_pkg::ADDR_REP_XY) begin
      d = planar_repetition_count_r;  // R8
    end else if (a == mrm_pkg::ADDR_REP_Z) begin
      d = vertical_repetition_count_r;  // R8
    end
    return d;  // Reserved and unmapped addresses read zero.  R9
  endfunction

  // Two-flop synchronisers; a third sclk stage only for edge finding.
  always_ff @(posedge clock) begin
    if (srst) begin
      sckS1_r <= 1'b0;
      sckS2_r <= 1'b0;
      sckS3_r <= 1'b0;
      csS1_r  <= 1'b1;
      csS2_r  <= 1'b1;
      sdaS1_r <= 1'b0;
      sdaS2_r <= 1'b0;
    end else begin
      sckS1_r <= spiClk;
      sckS2_r <= sckS1_r;
      sckS3_r <= sckS2_r;
      csS1_r  <= chipSelN;
      csS2_r  <= csS1_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
    end
  end

  // Edge and byte decode.
  assign sckRise  = sckS2_r & ~sckS3_r;
  assign sckFall  = ~sckS2_r & sckS3_r;
  assign csActive = ~csS2_r;
  assign byteIn   = {shIn_r[6:0], sdaS2_r};
  assign byteDone = sckRise && (bitCnt_r == mrm_pkg::LAST_BIT);

  // Frame state machine: command byte, then write or read bytes.
  always_ff @(posedge clock) begin
    if (srst || !csActive) begin
      state_r  <= mrm_pkg::ST_IDLE;
      bitCnt_r <= 3'h0;
      shIn_r   <= 8'h00;
      addr_r   <= 7'h00;
    end else begin
      if (sckRise) begin
        shIn_r   <= byteIn;
        bitCnt_r <= bitCnt_r + 3'h1;
      end
      case (state_r)
        mrm_pkg::ST_IDLE: begin
          state_r <= mrm_pkg::ST_CMD;
        end
        mrm_pkg::ST_CMD: begin
          if (byteDone) begin
            addr_r  <= byteIn[6:0];
            state_r <= byteIn[mrm_pkg::RW_BIT] ? mrm_pkg::ST_READ
                                               : mrm_pkg::ST_WRITE;
          end
        end
        default: begin
          if (byteDone) begin
            addr_r <= addr_r + 7'h01;
          end
        end
      endcase
    end
  end

  // Read shifter: load at the command byte end and each read byte end, drive on falling sclk.
  always_ff @(posedge clock) begin
    if (srst || !csActive) begin
      txSh_r  <= 8'h00;
      txBit_r <= 1'b0;
    end else if (byteDone && state_r == mrm_pkg::ST_CMD) begin
      txSh_r <= rdMux(byteIn[6:0]);
    end else if (byteDone && state_r == mrm_pkg::ST_READ) begin
      txSh_r <= rdMux(addr_r + 7'h01);
    end else if (sckFall && state_r == mrm_pkg::ST_READ) begin
      txBit_r <= txSh_r[7];
      txSh_r  <= {txSh_r[6:0], 1'b0};
    end
  end

  // Pin drivers: three-wire turns the data pin around for reads.
  always_ff @(posedge clock) begin
    if (srst) begin
      sdaOe <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      sdaOe <= csActive && state_r == mrm_pkg::ST_READ && threeWire_r;  // R13
      sdoOe <= csActive && state_r == mrm_pkg::ST_READ && !threeWire_r;  // R13
    end
  end

  // Completed write bytes become a one-cycle strobe.
  always_ff @(posedge clock) begin
    if (srst) begin
      wrFire_r <= 1'b0;
      wrAddr_r <= 7'h00;
      wrData_r <= 8'h00;
    end else begin
      wrFire_r <= csActive && byteDone && state_r == mrm_pkg::ST_WRITE;
      wrAddr_r <= addr_r;
      wrData_r <= byteIn;
    end
  end

  // Soft reset needs both trigger bits and no suspend.
  assign softFire = wrFire_r && wrAddr_r == mrm_pkg::ADDR_PWR_CTL &&
                    wrData_r[mrm_pkg::SRST_HI_BIT] &&
                    wrData_r[mrm_pkg::SRST_LO_BIT] && powerOn_r;  // R11
  assign bankClear = !powerOn_r || softFire;  // R11 R12

  // Power control survives soft reset; trigger bits are never stored.
  always_ff @(posedge clock) begin
    if (srst) begin
      powerOn_r   <= mrm_pkg::RST_PWR_ON;
      threeWire_r <= mrm_pkg::RST_THREE_W;
      softPulse_r <= 1'b0;
    end else begin
      softPulse_r <= softFire;  // R11
      if (wrFire_r && wrAddr_r == mrm_pkg::ADDR_PWR_CTL) begin
        powerOn_r   <= wrData_r[mrm_pkg::PWR_ON_BIT];  // R12
        threeWire_r <= wrData_r[mrm_pkg::THREE_W_BIT];  // R13
      end
    end
  end

  // Writable control registers; suspend holds them at reset values.
  always_ff @(posedge clock) begin
    if (srst || bankClear) begin
      opCtl_r   <= mrm_pkg::RST_OP_CTL;
      intEn_r   <= mrm_pkg::RST_INT_EN;
      pinCfg_r  <= mrm_pkg::RST_PIN_CFG;
      lowThr_r  <= mrm_pkg::RST_THR;
      highThr_r <= mrm_pkg::RST_THR;
      planar_repetition_count_r   <= mrm_pkg::RST_REP;  // R8
      vertical_repetition_count_r    <= mrm_pkg::RST_REP;  // R8
    end else if (wrFire_r) begin
      if (wrAddr_r == mrm_pkg::ADDR_OP_CTL) begin
        opCtl_r <= wrData_r;
      end else if (wrAddr_r == mrm_pkg::ADDR_INT_EN) begin
        intEn_r <= wrData_r;
      end else if (wrAddr_r == mrm_pkg::ADDR_PIN_CFG) begin
        pinCfg_r <= wrData_r;
      end else if (wrAddr_r == mrm_pkg::ADDR_LOW_THR) begin
        lowThr_r <= wrData_r;
      end else if (wrAddr_r == mrm_pkg::ADDR_HIGH_THR) begin
        highThr_r <= wrData_r;
      end else if (wrAddr_r == mrm_pkg::ADDR_REP_XY) begin
        planar_repetition_count_r <= wrData_r;  // R8
      end else if (wrAddr_r == mrm_pkg::ADDR_REP_Z) begin
        vertical_repetition_count_r <= wrData_r;  // R8
      end
    end
  end

  // Measurement results: loaded only by the engine, never by writes.
  always_ff @(posedge clock) begin
    if (srst || bankClear) begin
      xField_r   <= '0;
      yField_r   <= '0;
      zField_r   <= '0;
      hall_r     <= '0;
      xCheck_r   <= mrm_pkg::RST_CHECK;  // R6
      yCheck_r   <= mrm_pkg::RST_CHECK;  // R6
      zCheck_r   <= mrm_pkg::RST_CHECK;  // R6
      ready_r    <= 1'b0;
      intFlags_r <= mrm_pkg::RST_INT_FLAGS;
    end else begin
      intFlags_r <= intFlagsIn;  // R14
      if (sampleLoad) begin
        xField_r <= xField;  // R14
        yField_r <= yField;
        zField_r <= zField;
        hall_r   <= hallValue;
        xCheck_r <= xCheck;
        yCheck_r <= yCheck;
        zCheck_r <= zCheck;
        ready_r  <= sampleAvail;
      end
    end
  end

  // Outputs straight from flops.
  assign sdaOut                  = txBit_r;
  assign sdoOut                  = txBit_r;
  assign powerOn                 = powerOn_r;
  assign threeWireSelect         = threeWire_r;
  assign softResetPulse          = softPulse_r;
  assign opControl               = opCtl_r;
  assign intEnables              = intEn_r;
  assign intPinConfig            = pinCfg_r;
  assign lowThreshold            = lowThr_r;
  assign highThreshold           = highThr_r;
  assign planarRepetitionCount   = planar_repetition_count_r;
  assign verticalRepetitionCount = vertical_repetition_count_r;

endmodule

// file: core/mrm_pkg.sv
// Purpose: Shared constants of the magnetometer register bank.
// Assumes: Seven-bit register addresses and eight-bit register data.
// Notes:   Every offset lives here, with power control field positions and named reset values.
package mrm_pkg;

  // Register offsets.
  localparam logic [6:0] ADDR_IDENT     = 7'h40;
  localparam logic [6:0] ADDR_RSVD      = 7'h41;
  localparam logic [6:0] ADDR_X_LOW     = 7'h42;
  localparam logic [6:0] ADDR_X_HIGH    = 7'h43;
  localparam logic [6:0] ADDR_Y_LOW     = 7'h44;
  localparam logic [6:0] ADDR_Y_HIGH    = 7'h45;
  localparam logic [6:0] ADDR_Z_LOW     = 7'h46;
  localparam logic [6:0] ADDR_Z_HIGH    = 7'h47;
  localparam logic [6:0] ADDR_HALL_LOW  = 7'h48;
  localparam logic [6:0] ADDR_HALL_HIGH = 7'h49;
  localparam logic [6:0] ADDR_INT_FLAGS = 7'h4a;
  localparam logic [6:0] ADDR_PWR_CTL   = 7'h4b;
  localparam logic [6:0] ADDR_OP_CTL    = 7'h4c;
  localparam logic [6:0] ADDR_INT_EN    = 7'h4d;
  localparam logic [6:0] ADDR_PIN_CFG   = 7'h4e;
  localparam logic [6:0] ADDR_LOW_THR   = 7'h4f;
  localparam logic [6:0] ADDR_HIGH_THR  = 7'h50;
  localparam logic [6:0] ADDR_REP_XY    = 7'h51;
  localparam logic [6:0] ADDR_REP_Z     = 7'h52;

  // Reset values.
  localparam logic [7:0] RST_INT_FLAGS = 8'h00;
  localparam logic [7:0] RST_OP_CTL    = 8'h06;
  localparam logic [7:0] RST_INT_EN    = 8'h3f;
  localparam logic [7:0] RST_PIN_CFG   = 8'h07;
  localparam logic [7:0] RST_THR       = 8'h00;
  localparam logic [7:0] RST_REP       = 8'h00;
  localparam logic       RST_PWR_ON    = 1'b1;
  localparam logic       RST_THREE_W   = 1'b0;
  localparam logic       RST_CHECK     = 1'b1;

  // Power control field positions.
  localparam int PWR_ON_BIT  = 0;
  localparam int SRST_LO_BIT = 1;
  localparam int THREE_W_BIT = 2;
  localparam int SRST_HI_BIT = 7;

  // Field widths.
  localparam int XY_W   = 13;
  localparam int Z_W    = 15;
  localparam int HALL_W = 14;

  // Serial frame: bits in a byte, read flag position in the command.
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int         RW_BIT   = 7;

  // Serial frame states; idle to command to write each flip one bit, command to read flips two.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_WRITE = 2'b11,
    ST_READ  = 2'b10
  } mrm_state_t;

endpackage

// file: tb/mrm_assertions.sv
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock domain; srst is synchronous and active high.
// Notes:   Bound to every instance of the register bank.
`timescale 1ns/1ps
module mrm_assertions (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       chipSelN,
  input wire logic       sdaOe,
  input wire logic       sdoOe,
  input wire logic       powerOn,
  input wire logic       threeWireSelect,
  input wire logic       softResetPulse,
  input wire logic [7:0] opControl,
  input wire logic [7:0] intEnables,
  input wire logic [7:0] intPinConfig,
  input wire logic [7:0] lowThreshold,
  input wire logic [7:0] highThreshold,
  input wire logic [7:0] planarRepetitionCount,
  input wire logic [7:0] verticalRepetitionCount
);
  logic bankReset;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // True while every control register holds its reset value.
  assign bankReset = opControl == mrm_pkg::RST_OP_CTL &&
    intEnables == mrm_pkg::RST_INT_EN && intPinConfig == mrm_pkg::RST_PIN_CFG
    && lowThreshold == mrm_pkg::RST_THR && highThreshold == mrm_pkg::RST_THR
    && planarRepetitionCount == mrm_pkg::RST_REP
    && verticalRepetitionCount == mrm_pkg::RST_REP;

  // Two suspended cycles in a row, and a soft reset pulse that ends.
  sequence s_suspended;
    !powerOn ##1 !powerOn;
  endsequence
  sequence s_reset_pulse;
    softResetPulse ##1 !softResetPulse;
  endsequence

  a_oe_exclusive: assert property (!(sdaOe && sdoOe))
    else $error("both data pins driven at once");
  a_three_wire_pin: assert property (sdaOe |-> threeWireSelect)
    else $error("shared data pin driven in four-wire mode");
  a_four_wire_pin: assert property (sdoOe |-> !threeWireSelect)
    else $error("output pin driven in three-wire mode");
  a_idle_released: assert property (chipSelN [*8] |-> !sdaOe && !sdoOe)
    else $error("data pin driven while deselected");
  a_pulse_single: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse longer than one cycle");
  a_pulse_powered: assert property (softResetPulse |-> $past(powerOn))
    else $error("soft reset ran in suspend");
  a_sreset_clears: assert property (s_reset_pulse |-> ##[0:2] bankReset)
    else $error("soft reset left a register set");
  a_suspend_holds: assert property (s_suspended |-> bankReset)
    else $error("register changed in suspend");
  a_wake_clean: assert property ($rose(powerOn) |-> ##[0:2] bankReset)
    else $error("wake from suspend kept old values");
  a_reset_values: assert property ($past(srst) |->
    bankReset && powerOn && !threeWireSelect)
    else $error("wrong value after reset");
endmodule

bind mrm_register_bank mrm_assertions chk (.*);

// file: tb/mrm_host_model.sv
// Purpose: Behavioural host that runs serial frames into the bank.
// Assumes: Mode 3, clock idles high, 160 ns serial clock period.
// Notes:   Reads are sampled late in the high phase, well after the
//          bank has moved its data bit.
`timescale 1ns/1ps
module mrm_host_model (
  output logic      spiClk,
  output logic      chipSelN,
  output logic      sdaDrv,
  output logic      sdaEn,
  input  wire logic sdaWire,
  input  wire logic sdoOut,
  input  wire logic sdoOe
);
  // Idle lines: serial clock high, select released, data driven.
  initial begin
    spiClk = 1'b1;
    chipSelN = 1'b1;
    sdaDrv = 1'b0;
    sdaEn = 1'b1;
  end

  // Shifts one byte out on falls and samples the answer before the next.
  task automatic shift(input logic [7:0] tx, input logic tri3,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiClk = 1'b0;
      sdaDrv = tx[i];
      #80;
      spiClk = 1'b1;
      #79;
      rx[i] = tri3 ? sdaWire : sdoOe ? sdoOut : ~sdoOut;
      #1;
    end
  endtask

  // One frame: command byte, then n data bytes with auto-increment.
  task automatic frame(input logic [7:0] cmd, input int n, input logic tri3,
                       inout logic [7:0] dat [12]);
    logic [7:0] rx;
    #7;
    chipSelN = 1'b0;
    #80;
    shift(cmd, 1'b0, rx);
    // Releases the shared pin so the bank can answer on it.
    if (cmd[7] && tri3)
      sdaEn = 1'b0;
    for (int k = 0; k < n; k++) begin
      shift(dat[k], tri3, rx);
      if (cmd[7])
        dat[k] = rx;
    end
    #160;
    chipSelN = 1'b1;
    sdaEn = 1'b1;
    #200;
  endtask
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench of the register bank.
// Assumes: Host model drives the serial pins; bench drives the rest.
// Notes:   Expected values come from the bench's own stimulus.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ID_TB = 8'h5c;  // Arbitrary value.
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        spiClk, chipSelN, sdaDrv, sdaEn, sdaIn;
  logic        sdaOut, sdaOe, sdoOut, sdoOe, sampleLoad = 1'b0;
  logic [12:0] xField = '0, yField = '0;
  logic [14:0] zField = '0;
  logic [13:0] hallValue = '0;
  logic        xCheck = 1'b1, yCheck = 1'b1, zCheck = 1'b1;
  logic        sampleAvail = 1'b0;
  logic [7:0]  intFlagsIn = '0;
  logic        powerOn, threeWireSelect, softResetPulse;
  logic [7:0]  opControl, intEnables, intPinConfig, lowThreshold;
  logic [7:0]  highThreshold, planarRepetitionCount, verticalRepetitionCount;
  logic [7:0]  buf8 [12];
  logic [7:0]  ctl [7];
  logic [55:0] ctlPk;
  logic [7:0]  rstTab [8] = '{8'h01, 8'h06, 8'h3f, 8'h07, 8'h00, 8'h00,
                              8'h00, 8'h00};
  int          mismatches = 0, checked = 0, cycles = 0, pulseCnt = 0;

  mrm_register_bank #(.ID_VALUE(ID_TB)) dut (.*);
  mrm_host_model host (.spiClk(spiClk), .chipSelN(chipSelN),
    .sdaDrv(sdaDrv), .sdaEn(sdaEn), .sdaWire(sdaIn), .sdoOut(sdoOut),
    .sdoOe(sdoOe));

  // Clock, and the shared pin: undriven it shows the inverse of the last bit.
  always #10 clock = ~clock;
  assign sdaIn = sdaOe ? sdaOut : sdaEn ? sdaDrv : ~sdaDrv;

  // Counts soft reset pulses; also cuts a hung run short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (softResetPulse === 1'b1)
      pulseCnt <= pulseCnt + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    buf8[0] = d;
    host.frame({1'b0, a}, 1, 1'b0, buf8);
  endtask

  task automatic rd(input logic [6:0] a, input int n, input logic tri3);
    host.frame({1'b1, a}, n, tri3, buf8);
  endtask

  // Expected read value of a measurement or status register.
  function automatic logic [7:0] expReg(input logic [6:0] a);
    case (a)
      mrm_pkg::ADDR_X_LOW:     return {xField[4:0], 2'b00, xCheck};
      mrm_pkg::ADDR_X_HIGH:    return xField[12:5];
      mrm_pkg::ADDR_Y_LOW:     return {yField[4:0], 2'b00, yCheck};
      mrm_pkg::ADDR_Y_HIGH:    return yField[12:5];
      mrm_pkg::ADDR_Z_LOW:     return {zField[6:0], zCheck};
      mrm_pkg::ADDR_Z_HIGH:    return zField[14:7];
      mrm_pkg::ADDR_HALL_LOW:  return {hallValue[5:0], 1'b0, sampleAvail};
      mrm_pkg::ADDR_HALL_HIGH: return hallValue[13:6];
      default:                 return intFlagsIn;
    endcase
  endfunction

  // Burst reads the measurement and status block and compares it.
  task automatic scan(input logic tri3);
    rd(mrm_pkg::ADDR_X_LOW, 9, tri3);
    for (int i = 0; i < 9; i++)
      check(buf8[i], expReg(mrm_pkg::ADDR_X_LOW + 7'(i)));
  endtask

  // Burst reads power control up to the last count, against reset values.
  task automatic rst_scan();
    rd(mrm_pkg::ADDR_PWR_CTL, 8, 1'b0);
    for (int i = 0; i < 8; i++)
      check(buf8[i], rstTab[i]);
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'hc873b5ac));
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    repeat (4) @(posedge clock);
    rst_scan();
    rd(mrm_pkg::ADDR_IDENT, 1, 1'b0);
    check(buf8[0], ID_TB);
    scan(1'b0);
    // Random loads, with writes aimed at read-only places in between.
    for (int n = 0; n < 3; n++) begin
      @(posedge clock);
      #1 {xField, yField, zField, hallValue} = 55'({$urandom, $urandom});
      {xCheck, yCheck, zCheck, sampleAvail} = 4'($urandom);
      intFlagsIn = 8'($urandom);
      sampleLoad = 1'b1;
      @(posedge clock);
      #1 sampleLoad = 1'b0;
      wr(7'h40 + 7'($urandom_range(0, 10)), 8'($urandom));
      scan(1'b0);
    end
    // The reserved place takes no write and reads zero.
    wr(mrm_pkg::ADDR_RSVD, 8'hff);
    rd(mrm_pkg::ADDR_RSVD, 1, 1'b0);
    check(buf8[0], 8'h00);
    // Control and count registers take random values.
    for (int i = 0; i < 7; i++) begin
      ctl[i] = 8'($urandom);
      wr(mrm_pkg::ADDR_OP_CTL + 7'(i), ctl[i]);
    end
    ctlPk = {>>{ctl}};
    check({opControl, intEnables, intPinConfig, lowThreshold, highThreshold,
      planarRepetitionCount, verticalRepetitionCount}, ctlPk);
    rd(mrm_pkg::ADDR_OP_CTL, 7, 1'b0);
    for (int i = 0; i < 7; i++)
      check(buf8[i], ctl[i]);
    // Soft reset clears everything but power control.
    @(posedge clock);
    #1 {xField, yField, zField, hallValue, sampleAvail} = '0;
    {xCheck, yCheck, zCheck} = 3'b111;
    intFlagsIn = 8'h00;
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h83);
    check(64'(pulseCnt), 64'h1);
    rst_scan();
    scan(1'b0);
    // Suspend: identification hidden, writes and soft reset refused.
    wr(mrm_pkg::ADDR_REP_XY, 8'h5a);
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h00);
    check(powerOn, 1'b0);
    rd(mrm_pkg::ADDR_IDENT, 1, 1'b0);
    check(buf8[0], 8'h00);
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h82);
    wr(mrm_pkg::ADDR_REP_Z, 8'h3c);
    check({8'(pulseCnt), powerOn, verticalRepetitionCount},
      {8'h01, 1'b0, 8'h00});
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h01);
    rst_scan();
    // Three-wire reads come back on the shared pin.
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h05);
    check(threeWireSelect, 1'b1);
    wr(mrm_pkg::ADDR_REP_Z, 8'hc3);
    rd(mrm_pkg::ADDR_REP_Z, 1, 1'b1);
    check(buf8[0], 8'hc3);
    wr(mrm_pkg::ADDR_PWR_CTL, 8'h01);
    check(threeWireSelect, 1'b0);
    close_out();
  end
endmodule
